// ---- logic/hpm_cfg.svh ----
// constants for the headphone monitor, meter and alert tone block
// assumes a 50 MHz clock and a 48 kHz sample strobe from the audio path
`ifndef HPM_CFG_SVH
`define HPM_CFG_SVH

`define HPM_CLK_PERIOD_NS 20
`define HPM_FS_KHZ 48
// register indices on the 4-bit register port
`define HPM_A_CTRL 4'h0
`define HPM_A_HPSRC 4'h1
`define HPM_A_FAV 4'h2
`define HPM_A_PBSRC 4'h3
`define HPM_A_WARN 4'h4
`define HPM_A_TLVL 4'h5
`define HPM_A_TFREQ 4'h6
`define HPM_A_EXTTH 4'h7
`define HPM_A_TRKTH 4'h8
`define HPM_A_STATUS 4'h9
// ctrl fields
`define HPM_C_MODE 2:0
`define HPM_C_RECTONE 3
`define HPM_C_WARN 4
`define HPM_C_PUSHFAV 5
`define HPM_C_ROUTE 7:6
// synchronised pin vector positions
`define HPM_P_REC 0
`define HPM_P_PLAY 1
`define HPM_P_PUSH 2
`define HPM_P_TONE 3
`define HPM_P_ERR 4
`define HPM_P_MUTE 6:5
`define HPM_P_BATT 7
`define HPM_P_EXT 8
`define HPM_NPIN 9
// supply levels in 0.1 V steps
`define HPM_BATT_LOW 8'h41
`define HPM_EXT_LOW_RST 8'h6e
// levels against 16-bit full scale
`define HPM_WARN_AMP_MAX 16'h2027
`define HPM_REC_TONE_AMP 16'h2027
`define HPM_TONE_FS 16'h7fff
`define HPM_IN_PEAK_TH 16'h5a9d
`define HPM_TONE_ATT_MAX 6'h28
`define HPM_TONE_FMIN 14'h0064
`define HPM_TONE_FMAX 14'h2710
`define HPM_TRKTH_RST 16'h7fff
// segment thresholds, lowest segment in the low word
`define HPM_SEG_TH {16'h7fff, 16'h50c3, 16'h32f5, 16'h2027, 16'h198a, \
  16'h1449, 16'h101d, 16'h0ccd, 16'h0a2a, 16'h0813, 16'h066a, 16'h0518, \
  16'h040c, 16'h0336, 16'h028d, 16'h0207, 16'h019c, 16'h0148, 16'h0068}
// tones
`define HPM_F_START_HZ 440
`define HPM_F_STOP_HZ 220
`define HPM_F_LOW_HZ 880
`define HPM_F_ERR_HZ 1000
`define HPM_NCO_K ((64'h1_0000_0000 * `HPM_CLK_PERIOD_NS) / 64'd1000000000)
`define HPM_BEEP_MS 150
`define HPM_GAP_MS 100
`define HPM_LOWBAT_S 20
`define HPM_BEEP_CYC (`HPM_BEEP_MS * 1000000 / `HPM_CLK_PERIOD_NS)
`define HPM_GAP_CYC (`HPM_GAP_MS * 1000000 / `HPM_CLK_PERIOD_NS)
`define HPM_LOWBAT_CYC (`HPM_LOWBAT_S * (1000000000 / `HPM_CLK_PERIOD_NS))
// meter timing in sample strobes
`define HPM_VU_TAU_MS 300
`define HPM_VU_STEP_SAMPLES (`HPM_VU_TAU_MS * `HPM_FS_KHZ / 4)
`define HPM_PK_HOLD_S 3
`define HPM_PK_HOLD_SAMPLES (`HPM_PK_HOLD_S * `HPM_FS_KHZ * 1000)
`define HPM_PK_DECAY_SAMPLES 48

`endif

// ---- logic/hpm_pkg.sv ----
// types for the headphone monitor, meter and alert tone block
// assumes hpm_cfg.svh carries every number
package hpm_pkg;

  typedef enum logic [2:0] {MODE_VU, MODE_PEAK, MODE_PKHOLD, MODE_VU_PEAK,
                            MODE_VU_PKHOLD} hpm_mode_t;
  typedef enum logic [2:0] {SRC_IN_ST, SRC_TRK_ST, SRC_IN_MS, SRC_TRK_MS,
                            SRC_IN1, SRC_IN2, SRC_IN_SUM,
                            SRC_NO_CHANGE} hpm_src_t;
  typedef enum logic [1:0] {ROUTE_OUT, ROUTE_OUT_TRK, ROUTE_TRK,
                            ROUTE_OFF} hpm_route_t;
  typedef enum logic [1:0] {A_IDLE, A_ON, A_GAP} hpm_aseq_t;

  typedef struct packed {
    logic signed [15:0] in1;
    logic signed [15:0] in2;
    logic signed [15:0] trk_a;
    logic signed [15:0] trk_b;
  } hpm_samples_t;

  typedef struct packed {
    hpm_mode_t mode;
    logic rec_tones_en;
    logic warn_en;
    logic push_fav;
    hpm_route_t route;
    hpm_src_t hp_src;
    hpm_src_t fav;
    hpm_src_t pb_src;
    logic [3:0] warn_lvl;
    logic [5:0] tone_att;
    logic [13:0] tone_freq;
    logic [7:0] ext_th;
    logic [15:0] trk_th;
    logic [8:0] pin_s1;
    logic [8:0] pin_s2;
    logic [8:0] pin_d;
    logic [7:0] batt_s1;
    logic [7:0] batt_s2;
    logic [7:0] ext_s1;
    logic [7:0] ext_s2;
    hpm_aseq_t aseq;
    logic [31:0] acnt;
    logic [1:0] apulses;
    logic [31:0] ainc;
    logic [31:0] aphase;
    logic [15:0] aamp;
    logic [31:0] lbcnt;
    logic low;
    logic [31:0] tphase;
    logic tone_ok;
    logic tone_on;
    logic [1:0][15:0] vu;
    logic [1:0][15:0] pk;
    logic [1:0][19:0] hold;
    logic [11:0] dcnt;
    logic [11:0] vcnt;
    logic [22:0] blink;
    logic [1:0] trk_over;
    logic hp_over;
    logic [1:0][18:0] seg;
    logic [15:0] hp_l;
    logic [15:0] hp_r;
    logic [1:0] in_pk;
    logic [1:0] trk_led;
    logic [15:0] tone_smp;
    logic tone_out;
    logic tone_trk;
    logic [15:0] rdata;
  } hpm_state_t;

endpackage

// ---- logic/hpm_monitor.sv ----
// headphone monitor: source select, ms decode, alert tones, level meter,
// peak leds and test tone oscillator
// assumes samples arrive on this clock with a one-cycle smp_valid strobe;
// panel pins and supply readings are asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "hpm_cfg.svh"

module hpm_monitor #(
  parameter int unsigned BEEP_CYC = `HPM_BEEP_CYC,
  parameter int unsigned GAP_CYC = `HPM_GAP_CYC,
  parameter int unsigned LOWBAT_CYC = `HPM_LOWBAT_CYC,
  parameter int unsigned VU_STEP_SAMPLES = `HPM_VU_STEP_SAMPLES,
  parameter int unsigned PEAK_HOLD_SAMPLES = `HPM_PK_HOLD_SAMPLES,
  parameter int unsigned PEAK_DECAY_SAMPLES = `HPM_PK_DECAY_SAMPLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire hpm_pkg::hpm_samples_t smp,
  input wire logic smp_valid,
  input wire logic rec_pin,
  input wire logic play_pin,
  input wire logic push_pin,
  input wire logic tone_btn_pin,
  input wire logic err_pin,
  input wire logic [1:0] mute_pin,
  input wire logic batt_present_pin,
  input wire logic ext_present_pin,
  input wire logic [7:0] batt_volt,
  input wire logic [7:0] ext_volt,
  output logic [15:0] hp_l,
  output logic [15:0] hp_r,
  output logic hp_peak_led,
  output logic [18:0] meter_l,
  output logic [18:0] meter_r,
  output logic [1:0] in_peak_led,
  output logic [1:0] trk_peak_led,
  output logic [15:0] tone_sample,
  output logic tone_to_out,
  output logic tone_to_trk,
  output logic low_supply
);

  localparam logic [18:0][15:0] SEG_TH = `HPM_SEG_TH;

  hpm_pkg::hpm_state_t q;
  hpm_pkg::hpm_state_t n;

  logic [1:0][18:0] lit_vu;
  logic [1:0][18:0] lit_pk;
  logic [1:0][18:0] dot;
  logic rec, play, tbtn, rec_rise, rec_fall, play_rise, push_rise, err_rise;
  logic lb_t, vtick, dtick, hold_mode;
  logic signed [16:0] pl, pr, a17;
  logic signed [17:0] sl, sr;
  logic [15:0] warn_amp, tamp, mag_v;
  logic [13:0] tf;
  logic [5:0] tatt;
  logic signed [16:0] vd;
  logic [15:0] tr_mag;
  logic [1:0] mute_s;

  function automatic logic [15:0] mag(input logic signed [15:0] x);
    mag = x[15] ? 16'(-x) : 16'(x);
  endfunction

  function automatic logic signed [16:0] sx(input logic signed [15:0] x);
    sx = 17'(x);
  endfunction

  function automatic logic clipped(input logic signed [17:0] v);
    clipped = (v > 18'sh07fff) || (v < -18'sh08000);
  endfunction

  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh07fff) begin
      sat16 = 16'h7fff;
    end else if (v < -18'sh08000) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // segment compare per channel and per segment
  for (genvar c = 0; c < 2; c++) begin : g_ch
    for (genvar i = 0; i < 19; i++) begin : g_seg
      assign lit_vu[c][i] = q.vu[c] >= SEG_TH[i];
      assign lit_pk[c][i] = q.pk[c] >= SEG_TH[i];
      if (i == 18) begin : g_top
        assign dot[c][i] = lit_pk[c][i];
      end else begin : g_mid
        assign dot[c][i] = lit_pk[c][i] & ~lit_pk[c][i+1];
      end
    end
  end

  always_comb begin
    n = q;
    n.pin_s1 = {ext_present_pin, batt_present_pin, mute_pin, err_pin,
                tone_btn_pin, push_pin, play_pin, rec_pin};
    n.pin_s2 = q.pin_s1;
    n.pin_d = q.pin_s2;
    n.batt_s1 = batt_volt;
    n.batt_s2 = q.batt_s1;
    n.ext_s1 = ext_volt;
    n.ext_s2 = q.ext_s1;
    rec = q.pin_s2[`HPM_P_REC];
    play = q.pin_s2[`HPM_P_PLAY];
    tbtn = q.pin_s2[`HPM_P_TONE];
    rec_rise = rec & ~q.pin_d[`HPM_P_REC];
    rec_fall = ~rec & q.pin_d[`HPM_P_REC];
    play_rise = play & ~q.pin_d[`HPM_P_PLAY];
    push_rise = q.pin_s2[`HPM_P_PUSH] & ~q.pin_d[`HPM_P_PUSH];
    err_rise = q.pin_s2[`HPM_P_ERR] & ~q.pin_d[`HPM_P_ERR];
    mute_s = q.pin_s2[`HPM_P_MUTE];

    // register writes; panel events below take precedence over software
    if (reg_wr) begin
      case (reg_addr)
        `HPM_A_CTRL: begin
          n.mode = hpm_pkg::hpm_mode_t'(reg_wdata[`HPM_C_MODE]);
          n.rec_tones_en = reg_wdata[`HPM_C_RECTONE];
          n.warn_en = reg_wdata[`HPM_C_WARN];
          n.push_fav = reg_wdata[`HPM_C_PUSHFAV];
          n.route = hpm_pkg::hpm_route_t'(reg_wdata[`HPM_C_ROUTE]);
        end
        `HPM_A_HPSRC: n.hp_src = hpm_pkg::hpm_src_t'(reg_wdata[2:0]);
        `HPM_A_FAV: n.fav = hpm_pkg::hpm_src_t'(reg_wdata[2:0]);
        `HPM_A_PBSRC: n.pb_src = hpm_pkg::hpm_src_t'(reg_wdata[2:0]);
        `HPM_A_WARN: n.warn_lvl = reg_wdata[3:0];
        `HPM_A_TLVL: n.tone_att = reg_wdata[5:0];
        `HPM_A_TFREQ: n.tone_freq = reg_wdata[13:0];
        `HPM_A_EXTTH: n.ext_th = reg_wdata[7:0];
        `HPM_A_TRKTH: n.trk_th = reg_wdata;
        default: ;
      endcase
    end
    if ((rec | play) & push_rise & q.push_fav) begin
      n.hp_src = q.fav;
    end
    if (play_rise & (q.pb_src != hpm_pkg::SRC_NO_CHANGE)) begin
      n.hp_src = q.pb_src;
    end

    // supply watch; an absent supply never raises the warning
    n.low = (q.pin_s2[`HPM_P_BATT] & (q.batt_s2 <= `HPM_BATT_LOW)) |
            (q.pin_s2[`HPM_P_EXT] & (q.ext_s2 <= q.ext_th));
    if (!q.low || q.lbcnt == 32'(LOWBAT_CYC - 1)) begin
      n.lbcnt = 32'h0;
    end else begin
      n.lbcnt = q.lbcnt + 32'h1;
    end
    lb_t = q.low & (q.lbcnt == 32'h0) & q.warn_en;
    warn_amp = (q.warn_lvl == 4'h0) ? 16'h0000 :
               16'(`HPM_WARN_AMP_MAX >> (q.warn_lvl - 4'h1));

    // alert tone sequencer: pulses of BEEP_CYC separated by GAP_CYC
    n.aphase = q.aphase + q.ainc;
    case (q.aseq)
      hpm_pkg::A_ON: begin
        n.acnt = q.acnt + 32'h1;
        if (q.acnt == 32'(BEEP_CYC - 1)) begin
          n.acnt = 32'h0;
          n.aseq = (q.apulses > 2'h1) ? hpm_pkg::A_GAP : hpm_pkg::A_IDLE;
        end
      end
      hpm_pkg::A_GAP: begin
        n.acnt = q.acnt + 32'h1;
        if (q.acnt == 32'(GAP_CYC - 1)) begin
          n.acnt = 32'h0;
          n.aseq = hpm_pkg::A_ON;
          n.apulses = q.apulses - 2'h1;
        end
      end
      default: begin
        n.aseq = hpm_pkg::A_IDLE;
        n.acnt = 32'h0;
      end
    endcase
    // later triggers override earlier ones in the same cycle
    if (lb_t) begin
      n.aseq = hpm_pkg::A_ON;
      n.apulses = 2'h3;
      n.ainc = 32'(`HPM_F_LOW_HZ * `HPM_NCO_K);
      n.aamp = warn_amp;
    end
    if (err_rise & q.warn_en & (q.warn_lvl != 4'h0)) begin
      n.aseq = hpm_pkg::A_ON;
      n.apulses = 2'h1;
      n.ainc = 32'(`HPM_F_ERR_HZ * `HPM_NCO_K);
      n.aamp = warn_amp;
    end
    if (rec_rise & q.rec_tones_en) begin
      n.aseq = hpm_pkg::A_ON;
      n.apulses = 2'h1;
      n.ainc = 32'(`HPM_F_START_HZ * `HPM_NCO_K);
      n.aamp = `HPM_REC_TONE_AMP;
    end
    if (rec_fall & q.rec_tones_en) begin
      n.aseq = hpm_pkg::A_ON;
      n.apulses = 2'h2;
      n.ainc = 32'(`HPM_F_STOP_HZ * `HPM_NCO_K);
      n.aamp = `HPM_REC_TONE_AMP;
    end
    if (n.aseq == hpm_pkg::A_ON && q.aseq != hpm_pkg::A_ON) begin
      n.acnt = 32'h0;
      n.aphase = 32'h0;
    end

    // headphone program
    case (q.hp_src)
      hpm_pkg::SRC_IN_ST: begin
        pl = sx(smp.in1);
        pr = sx(smp.in2);
      end
      hpm_pkg::SRC_TRK_ST: begin
        pl = sx(smp.trk_a);
        pr = sx(smp.trk_b);
      end
      hpm_pkg::SRC_IN_MS: begin
        pl = (sx(smp.in1) + sx(smp.in2)) >>> 1;
        pr = (sx(smp.in1) - sx(smp.in2)) >>> 1;
      end
      hpm_pkg::SRC_TRK_MS: begin
        pl = (sx(smp.trk_a) + sx(smp.trk_b)) >>> 1;
        pr = (sx(smp.trk_a) - sx(smp.trk_b)) >>> 1;
      end
      hpm_pkg::SRC_IN1: begin
        pl = sx(smp.in1);
        pr = sx(smp.in1);
      end
      hpm_pkg::SRC_IN2: begin
        pl = sx(smp.in2);
        pr = sx(smp.in2);
      end
      hpm_pkg::SRC_IN_SUM: begin
        pl = (sx(smp.in1) + sx(smp.in2)) >>> 1;
        pr = pl;
      end
      default: begin
        pl = 17'sh00000;
        pr = 17'sh00000;
      end
    endcase
    // alert tones go to headphones only, never to outputs or tracks
    if (q.aseq == hpm_pkg::A_ON) begin
      a17 = q.aphase[31] ? 17'($signed({1'b0, q.aamp})) :
            -17'($signed({1'b0, q.aamp}));
    end else begin
      a17 = 17'sh00000;
    end
    sl = 18'(pl) + 18'(a17);
    sr = 18'(pr) + 18'(a17);

    // blink period doubles as the stretch time for the short overloads
    n.blink = q.blink + 23'h1;
    if (&q.blink) begin
      n.trk_over = 2'b00;
      n.hp_over = 1'b0;
    end
    hold_mode = (q.mode == hpm_pkg::MODE_PKHOLD) ||
                (q.mode == hpm_pkg::MODE_VU_PKHOLD);
    vtick = smp_valid && (q.vcnt == 12'(VU_STEP_SAMPLES - 1));
    dtick = smp_valid && (q.dcnt == 12'(PEAK_DECAY_SAMPLES - 1));
    mag_v = 16'h0000;
    tr_mag = 16'h0000;
    vd = 17'sh00000;
    if (smp_valid) begin
      n.vcnt = vtick ? 12'h000 : q.vcnt + 12'h001;
      n.dcnt = dtick ? 12'h000 : q.dcnt + 12'h001;
      n.hp_l = sat16(sl);
      n.hp_r = sat16(sr);
      if (clipped(sl) | clipped(sr)) begin
        n.hp_over = 1'b1;
      end
      n.in_pk[0] = (mag(smp.in1) >= `HPM_IN_PEAK_TH) |
                   mute_s[0];
      n.in_pk[1] = (mag(smp.in2) >= `HPM_IN_PEAK_TH) |
                   mute_s[1];
      for (int c = 0; c < 2; c++) begin
        tr_mag = (c == 0) ? mag(smp.trk_a) : mag(smp.trk_b);
        if (tr_mag > q.trk_th) begin
          n.trk_over[c] = 1'b1;
        end
        mag_v = tr_mag;
        // peak: instant attack, optional hold, then slow decay
        if (mag_v >= q.pk[c]) begin
          n.pk[c] = mag_v;
          n.hold[c] = hold_mode ? 20'(PEAK_HOLD_SAMPLES) : 20'h0;
        end else if (q.hold[c] != 20'h0) begin
          n.hold[c] = q.hold[c] - 20'h1;
        end else if (dtick) begin
          n.pk[c] = q.pk[c] - (q.pk[c] >> 3);
        end
        // vu is a first-order follower sampled every VU step
        if (vtick) begin
          vd = $signed({1'b0, mag_v}) - $signed({1'b0, q.vu[c]});
          n.vu[c] = 16'($signed({1'b0, q.vu[c]}) + (vd >>> 2));
        end
      end
    end
    for (int c = 0; c < 2; c++) begin
      case (q.mode)
        hpm_pkg::MODE_VU: n.seg[c] = lit_vu[c];
        hpm_pkg::MODE_PEAK: n.seg[c] = lit_pk[c];
        hpm_pkg::MODE_PKHOLD: n.seg[c] = lit_pk[c];
        default: n.seg[c] = lit_vu[c] | dot[c];
      endcase
    end
    n.trk_led = q.trk_over & {2{q.blink[22]}};

    // test tone: held button only; while recording only if held at start
    if (rec_rise) begin
      n.tone_ok = tbtn;
    end else if (!tbtn) begin
      n.tone_ok = 1'b0;
    end
    n.tone_on = tbtn & (q.route != hpm_pkg::ROUTE_OFF) &
                (~rec | n.tone_ok);
    tf = (q.tone_freq < `HPM_TONE_FMIN) ? `HPM_TONE_FMIN :
         (q.tone_freq > `HPM_TONE_FMAX) ? `HPM_TONE_FMAX :
         q.tone_freq;
    tatt = (q.tone_att > `HPM_TONE_ATT_MAX) ? `HPM_TONE_ATT_MAX :
           q.tone_att;
    // level steps are 6 dB wide; a finer law would need a lookup table
    tamp = `HPM_TONE_FS >> (tatt / 6'h06);
    n.tphase = q.tone_on ? q.tphase + 32'(tf * `HPM_NCO_K) : 32'h0;
    n.tone_smp = q.tone_on ? (q.tphase[31] ? tamp : 16'(-tamp)) : 16'h0000;
    n.tone_out = q.tone_on & ((q.route == hpm_pkg::ROUTE_OUT) |
                 (q.route == hpm_pkg::ROUTE_OUT_TRK));
    n.tone_trk = q.tone_on & ((q.route == hpm_pkg::ROUTE_TRK) |
                 (q.route == hpm_pkg::ROUTE_OUT_TRK));

    // read data stands for exactly the cycle after the read strobe
    n.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `HPM_A_CTRL: n.rdata = {8'h00, q.route, q.push_fav, q.warn_en,
                                q.rec_tones_en, q.mode};
        `HPM_A_HPSRC: n.rdata = {13'h0000, q.hp_src};
        `HPM_A_FAV: n.rdata = {13'h0000, q.fav};
        `HPM_A_PBSRC: n.rdata = {13'h0000, q.pb_src};
        `HPM_A_WARN: n.rdata = {12'h000, q.warn_lvl};
        `HPM_A_TLVL: n.rdata = {10'h000, q.tone_att};
        `HPM_A_TFREQ: n.rdata = {2'h0, q.tone_freq};
        `HPM_A_EXTTH: n.rdata = {8'h00, q.ext_th};
        `HPM_A_TRKTH: n.rdata = q.trk_th;
        `HPM_A_STATUS: n.rdata = {10'h000, q.hp_over, q.low, q.tone_on,
                                  q.aseq != hpm_pkg::A_IDLE, play, rec};
        default: n.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.mode <= hpm_pkg::MODE_VU_PEAK;
      q.warn_en <= 1'b1;
      q.route <= hpm_pkg::ROUTE_OUT;
      q.hp_src <= hpm_pkg::SRC_TRK_ST;
      q.fav <= hpm_pkg::SRC_TRK_ST;
      q.pb_src <= hpm_pkg::SRC_NO_CHANGE;
      q.warn_lvl <= 4'h1;
      q.tone_att <= 6'h14;
      q.tone_freq <= 14'h03e8;
      q.ext_th <= `HPM_EXT_LOW_RST;
      q.trk_th <= `HPM_TRKTH_RST;
      q.aseq <= hpm_pkg::A_IDLE;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign hp_l = q.hp_l;
  assign hp_r = q.hp_r;
  assign hp_peak_led = q.hp_over;
  assign meter_l = q.seg[0];
  assign meter_r = q.seg[1];
  assign in_peak_led = q.in_pk;
  assign trk_peak_led = q.trk_led;
  assign tone_sample = q.tone_smp;
  assign tone_to_out = q.tone_out;
  assign tone_to_trk = q.tone_trk;
  assign low_supply = q.low;

endmodule // hpm_monitor
`default_nettype wire

// ---- verification/hpm_audio_src.sv ----
// partner model: audio sample path feeding one strobed sample word
// assumes the bench sets the level; strobe every PERIOD clocks
`timescale 1ns/1ps
`default_nettype none
module hpm_audio_src #(
  parameter int PERIOD = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire hpm_pkg::hpm_samples_t level,
  output hpm_pkg::hpm_samples_t smp,
  output logic smp_valid
);
  logic [7:0] cnt_reg;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      cnt_reg <= 8'h00;
    else if (cnt_reg == 8'(PERIOD - 1))
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_reg + 8'h01;
  end
  assign smp_valid = (cnt_reg == 8'h00) && !sys_rst;
  // junk off the strobe, so sampling at the wrong time shows up
  assign smp = smp_valid ? level : ~level;
endmodule // hpm_audio_src
`default_nettype wire

// ---- verification/hpm_monitor_chk.sv ----
// port checker for hpm_monitor
// assumes the bind below; one clock domain
`timescale 1ns/1ps
`default_nettype none
module hpm_monitor_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire hpm_pkg::hpm_samples_t smp,
  input wire logic smp_valid,
  input wire logic rec_pin,
  input wire logic tone_btn_pin,
  input wire logic batt_present_pin,
  input wire logic ext_present_pin,
  input wire logic [7:0] batt_volt,
  input wire logic [1:0] in_peak_led,
  input wire logic tone_to_out,
  input wire logic tone_to_trk,
  input wire logic low_supply
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence thr_wr_rd;
    reg_wr && reg_addr == 4'h8 ##2 reg_rd && reg_addr == 4'h8;
  endsequence
  sequence batt_low_held;
    (batt_present_pin && batt_volt <= 8'h41)[*4];
  endsequence
  chk_rdata_stands: assert property (
    reg_rd ##1 !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outlived its cycle");
  chk_rdata_cause: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
    else $error("read data without a read");
  chk_unmapped_zero: assert property (
    reg_rd && reg_addr > 4'h9 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_thr_readback: assert property (
    thr_wr_rd |=> reg_rdata == $past(reg_wdata, 3))
    else $error("threshold readback wrong");
  chk_input_peak: assert property (
    smp_valid && smp.in1 >= 16'sh5a9d |=> in_peak_led[0])
    else $error("input peak led dark");
  chk_low_entry: assert property (
    batt_low_held |-> ##[0:4] low_supply)
    else $error("low supply missed");
  chk_low_none: assert property (
    (!batt_present_pin && !ext_present_pin)[*6] |-> !low_supply)
    else $error("low supply without supply");
  chk_tone_held: assert property (
    tone_to_out |-> $past(tone_btn_pin, 2) || $past(tone_btn_pin, 3)
      || $past(tone_btn_pin, 4) || $past(tone_btn_pin, 5))
    else $error("tone without button");
  chk_tone_lockout: assert property (
    $rose(tone_to_trk) |-> !$past(rec_pin, 5))
    else $error("tone reached tracks mid record");
endmodule // hpm_monitor_chk
bind hpm_monitor hpm_monitor_chk u_chk (.clock, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .smp, .smp_valid, .rec_pin,
  .tone_btn_pin, .batt_present_pin, .ext_present_pin, .batt_volt,
  .in_peak_led, .tone_to_out, .tone_to_trk, .low_supply);
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for hpm_monitor
// assumes the audio source model and the checker bind
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic rec_pin = 1'b0, play_pin = 1'b0, push_pin = 1'b0, err_pin = 1'b0;
  logic tone_btn_pin = 1'b0, batt_present_pin = 1'b0;
  logic ext_present_pin = 1'b0;
  logic [1:0] mute_pin = 2'h0;
  logic [7:0] batt_volt = 8'h42, ext_volt = 8'h00;
  logic [15:0] reg_rdata, hp_l, hp_r, tone_sample;
  logic [18:0] meter_l, meter_r;
  logic [1:0] in_peak_led, trk_peak_led;
  logic hp_peak_led, tone_to_out, tone_to_trk, low_supply, smp_valid;
  hpm_pkg::hpm_samples_t smp, lvl = '0;
  int err_total = 0, comparisons = 0, cyc = 0;
  logic seen;
  logic [19:0] rows [11] = '{20'h0_0013, 20'h1_0001, 20'h2_0001,
    20'h3_0007, 20'h4_0001, 20'h5_0014, 20'h6_03e8, 20'h7_006e,
    20'h8_7fff, 20'h9_0000, 20'hc_0000};
  always #10 clock = ~clock;
  hpm_audio_src u_src (.clock(clock), .sys_rst(sys_rst), .level(lvl),
    .smp(smp), .smp_valid(smp_valid));
  hpm_monitor #(.BEEP_CYC(20), .GAP_CYC(10), .LOWBAT_CYC(200),
    .VU_STEP_SAMPLES(4), .PEAK_HOLD_SAMPLES(16))
    DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .smp(smp), .smp_valid(smp_valid),
    .rec_pin(rec_pin), .play_pin(play_pin), .push_pin(push_pin),
    .tone_btn_pin(tone_btn_pin), .err_pin(err_pin), .mute_pin(mute_pin),
    .batt_present_pin(batt_present_pin), .ext_present_pin(ext_present_pin),
    .batt_volt(batt_volt), .ext_volt(ext_volt), .hp_l(hp_l), .hp_r(hp_r),
    .hp_peak_led(hp_peak_led), .meter_l(meter_l), .meter_r(meter_r),
    .in_peak_led(in_peak_led), .trk_peak_led(trk_peak_led),
    .tone_sample(tone_sample), .tone_to_out(tone_to_out),
    .tone_to_trk(tone_to_trk), .low_supply(low_supply));
  task automatic test_done;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, e);
  endtask
  task automatic hp_case(input logic [15:0] s, input logic [15:0] l,
      input logic [15:0] r);
    wr(4'h1, s);
    tick(20);
    chk(hp_l, l);
    chk(hp_r, r);
  endtask
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 11; i++)
      rd(rows[i][19:16], rows[i][15:0]);
    wr(4'h8, 16'h1234);
    rd(4'h8, 16'h1234);
    @(posedge clock) lvl <= '{16'sh2000, 16'sh1000, 16'sh0, 16'sh0};
    hp_case(16'h0002, 16'h1800, 16'h0800);
    hp_case(16'h0004, 16'h2000, 16'h2000);
    hp_case(16'h0000, 16'h2000, 16'h1000);
    chk({14'h0, in_peak_led}, 16'h0000);
    @(posedge clock) lvl <= '{16'sh5a9d, 16'sh1000, 16'sh0, 16'sh0};
    mute_pin <= 2'b10;
    tick(20);
    chk({14'h0, in_peak_led}, 16'h0003);
    @(posedge clock) lvl <= '{16'sh0100, 16'sh0100, 16'sh0, 16'sh0};
    mute_pin <= 2'b00;
    batt_present_pin <= 1'b1;
    tick(20);
    chk({15'h0, low_supply}, 16'h0000);
    wr(4'h0, 16'h0003);
    @(posedge clock) batt_volt <= 8'h41;
    err_pin <= 1'b1;
    repeat (40) begin
      tick(1);
      chk(hp_l, 16'h0100);
    end
    chk({15'h0, low_supply}, 16'h0001);
    @(posedge clock) err_pin <= 1'b0;
    batt_present_pin <= 1'b0;
    tick(6);
    wr(4'h0, 16'h0013);
    tick(6);
    seen = 1'b0;
    @(posedge clock) err_pin <= 1'b1;
    repeat (40) begin
      tick(1);
      if (hp_l === 16'he0d9)
        seen = 1'b1;
    end
    chk({15'h0, seen}, 16'h0001);
    @(posedge clock) err_pin <= 1'b0;
    ext_present_pin <= 1'b1;
    ext_volt <= 8'h6f;
    wr(4'h2, 16'h0004);
    wr(4'h0, 16'h0033);
    @(posedge clock) play_pin <= 1'b1;
    tick(6);
    rd(4'h1, 16'h0000);
    chk({15'h0, low_supply}, 16'h0000);
    @(posedge clock) push_pin <= 1'b1;
    tick(6);
    rd(4'h1, 16'h0004);
    @(posedge clock) push_pin <= 1'b0;
    play_pin <= 1'b0;
    ext_volt <= 8'h6e;
    wr(4'h3, 16'h0002);
    @(posedge clock) play_pin <= 1'b1;
    tick(6);
    rd(4'h1, 16'h0002);
    chk({15'h0, low_supply}, 16'h0001);
    wr(4'h0, 16'h0013);
    @(posedge clock) push_pin <= 1'b1;
    tick(6);
    rd(4'h1, 16'h0002);
    @(posedge clock) push_pin <= 1'b0;
    play_pin <= 1'b0;
    wr(4'h0, 16'h0053);
    @(posedge clock) tone_btn_pin <= 1'b1;
    tick(8);
    chk({14'h0, tone_to_out, tone_to_trk}, 16'h0003);
    chk(tone_sample, 16'hf001);
    @(posedge clock) rec_pin <= 1'b1;
    tick(8);
    chk({14'h0, tone_to_out, tone_to_trk}, 16'h0003);
    @(posedge clock) tone_btn_pin <= 1'b0;
    tick(8);
    chk({14'h0, tone_to_out, tone_to_trk}, 16'h0000);
    chk(tone_sample, 16'h0000);
    @(posedge clock) tone_btn_pin <= 1'b1;
    tick(8);
    chk({14'h0, tone_to_out, tone_to_trk}, 16'h0000);
    @(posedge clock) tone_btn_pin <= 1'b0;
    rec_pin <= 1'b0;
    tick(8);
    chk({15'h0, hp_peak_led}, 16'h0000);
    wr(4'h0, 16'h0011);
    @(posedge clock) lvl <= '{16'sh8000, 16'sh8000, 16'sh2027, 16'sh0};
    err_pin <= 1'b1;
    tick(30);
    chk({15'h0, hp_peak_led}, 16'h0001);
    chk(meter_l[18:3], 16'h1fff);
    chk(meter_r[18:3], 16'h0000);
    test_done();
  end
endmodule // testbench
`default_nettype wire
